// [rtl/arm_params.svh]
// Constants for the alarm match register block: offsets, fields, resets.
// Assumes inclusion by bare name from the block's design files.
`ifndef ARM_PARAMS_SVH
`define ARM_PARAMS_SVH

// Register offsets, alarm 0 then alarm 1
`define ARM_ADDR_ALM0_MIN   8'h0B
`define ARM_ADDR_ALM0_HOUR  8'h0C
`define ARM_ADDR_ALM0_DAY_OF_WEEK_VALUE 8'h0D
`define ARM_ADDR_ALM1_MIN   8'h12
`define ARM_ADDR_ALM1_HOUR  8'h13
`define ARM_ADDR_ALM1_DAY_OF_WEEK_VALUE 8'h14

// Field positions
`define ARM_MIN_HI          6
`define ARM_HOUR_HI         5
`define ARM_HOUR_FMT_BIT    6
`define ARM_WK_POL_BIT      7
`define ARM_WK_SEL_HI       6
`define ARM_WK_SEL_LO       4
`define ARM_WK_FLAG_BIT     3
`define ARM_WK_DAY_HI       2

// Reset values
`define ARM_RST_MIN         7'h00
`define ARM_RST_HOUR        6'h00
`define ARM_RST_SEL         3'h0
`define ARM_RST_DAY         3'h1
`define ARM_RST_POL         1'h0
`define ARM_RST_RDATA       8'h00
`define ARM_RD_UNMAPPED     8'h00

`endif

// [rtl/arm_pkg.sv]
// Types for the alarm match register block.
// Assumes the constants header is compiled alongside.
package arm_pkg;

    typedef enum logic [2:0] {
        ARM_CMP_SEC   = 3'h0,
        ARM_CMP_MIN   = 3'h1,
        ARM_CMP_HOUR  = 3'h2,
        ARM_CMP_DAY_OF_WEEK_VALUE = 3'h3,
        ARM_CMP_DATE  = 3'h4,
        ARM_CMP_ALL   = 3'h7
    } arm_cmp_sel_t;

    typedef struct packed {
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] sel;
        logic       flag;
        logic [2:0] day;
    } arm_alarm_t;

    typedef struct packed {
        arm_alarm_t [1:0] alm;
        logic             pol;
        logic [7:0]       rdata;
        logic             out_level;
    } arm_state_t;

endpackage : arm_pkg

// [rtl/arm_cmp_if.sv]
// Match values and current time handed to one alarm comparator.
// Assumes the register module drives all fields except hit.
`timescale 1ns/100ps
interface arm_cmp_if;
    logic [2:0] sel;
    logic [6:0] min_val;
    logic [5:0] hour_val;
    logic [2:0] day_val;
    logic [6:0] sec_val;
    logic [5:0] date_val;
    logic [4:0] mth_val;
    logic [6:0] cur_sec;
    logic [6:0] cur_min;
    logic [5:0] cur_hour;
    logic [2:0] cur_day;
    logic [5:0] cur_date;
    logic [4:0] cur_mth;
    logic       hit;

    modport regs (output sel, min_val, hour_val, day_val, sec_val,
                  date_val, mth_val, cur_sec, cur_min, cur_hour,
                  cur_day, cur_date, cur_mth, input hit);
    modport cmp  (input sel, min_val, hour_val, day_val, sec_val,
                  date_val, mth_val, cur_sec, cur_min, cur_hour,
                  cur_day, cur_date, cur_mth, output hit);
endinterface : arm_cmp_if

// [rtl/arm_alarm_cmp.sv]
// Combinational compare of one alarm against the current time.
// Assumes all values arrive as BCD with unimplemented bits stripped.
`timescale 1ns/100ps
module arm_alarm_cmp (
    arm_cmp_if.cmp c
);
    logic sec_eq;
    logic min_eq;
    logic hour_eq;
    logic day_eq;
    logic date_eq;
    logic mth_eq;

    function automatic logic field_eq(input logic [6:0] a,
                                      input logic [6:0] b);
        field_eq = (a == b);
    endfunction : field_eq

    always_comb
    begin
        sec_eq  = field_eq(c.sec_val, c.cur_sec);
        min_eq  = field_eq(c.min_val, c.cur_min);
        // Half-day bit sits inside the compared field in 12-hour mode
        hour_eq = field_eq({1'b0, c.hour_val}, {1'b0, c.cur_hour}); // R15
        day_eq  = field_eq({4'h0, c.day_val}, {4'h0, c.cur_day});
        date_eq = field_eq({1'b0, c.date_val}, {1'b0, c.cur_date});
        mth_eq  = field_eq({2'h0, c.mth_val}, {2'h0, c.cur_mth});
        case (c.sel) // R12
            arm_pkg::ARM_CMP_SEC:   c.hit = sec_eq;
            arm_pkg::ARM_CMP_MIN:   c.hit = min_eq;
            arm_pkg::ARM_CMP_HOUR:  c.hit = hour_eq;
            arm_pkg::ARM_CMP_DAY_OF_WEEK_VALUE: c.hit = day_eq;
            arm_pkg::ARM_CMP_DATE:  c.hit = date_eq;
            arm_pkg::ARM_CMP_ALL:
                c.hit = sec_eq & min_eq & hour_eq & day_eq & date_eq
                      & mth_eq;
            // Reserved codes never match
            default:                c.hit = 1'b0;
        endcase
    end
endmodule : arm_alarm_cmp

// [rtl/arm_match_regs.sv]
// Minutes, hours and weekday match registers of two alarms, with flags.
// Assumes a serial bus engine presents byte reads and writes by offset,
// and the timekeeping counters present current time images.
//
// Operation
// R1 - Alarm minutes bits 6 to 4 hold the BCD minute tens digit, 0 to 5.
// R2 - Alarm minutes bits 3 to 0 hold the BCD minute ones digit, 0 to 9.
// R3 - Bit 7 of alarm minutes and hours registers reads zero, writes lost.
// R4 - Hours bit 6 is read-only and mirrors the timekeeping hour format.
// R5 - Format bit one means 12-hour and zero 24-hour, steering bits 5-4.
// R6 - In 12-hour format bit 5 is the half-day indicator, one for PM.
// R7 - In 12-hour format bit 4 is the hour tens 0-1, bits 3-0 ones 0-9.
// R8 - In 24-hour format bits 5 and 4 hold the hour tens digit 0 to 2.
// R9 - Weekday bit 7 set makes the asserted alarm output high, else low.
// R10 - A software write of one never sets the alarm interrupt flag.
// R11 - Any write to a weekday register clears that alarm's flag.
// R12 - The compare select field picks seconds to all-fields matching.
// R13 - Hardware sets the flag when the selected comparison matches.
// R14 - A flag cleared while the match still holds is set again.
// R15 - Hours matching follows the current format, half-day included.
// R16 - Weekday bits 2 to 0 hold a software-defined day value 1 to 7.
`timescale 1ns/100ps
`include "arm_params.svh"
module arm_match_regs (
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire logic [7:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    input  wire logic [7:0]      cur_sec,
    input  wire logic [7:0]      cur_min,
    input  wire logic [7:0]      cur_hour,
    input  wire logic [7:0]      cur_day_of_week_value,
    input  wire logic [7:0]      cur_date,
    input  wire logic [7:0]      cur_mth,
    input  wire logic [1:0][7:0] alarm_sec_val,
    input  wire logic [1:0][7:0] alarm_date_val,
    input  wire logic [1:0][7:0] alarm_mth_val,
    input  wire logic [1:0]      alarm_enable,
    output logic      [1:0]      alarm_interrupt_flag,
    output logic                 alarm_output_polarity,
    output logic                 alarm_out_level
);
    arm_pkg::arm_state_t state_reg;
    arm_pkg::arm_state_t state_next;
    logic [1:0]          hit;
    logic [1:0]          any_vec;
    logic                hour_format;

    arm_cmp_if cmp_if [2] ();

    // Offset decode: which alarm, and which register of it
    function automatic logic [2:0] reg_sel(input logic [7:0] a,
                                           input logic       idx);
        logic [7:0] base;
        base = idx ? `ARM_ADDR_ALM1_MIN : `ARM_ADDR_ALM0_MIN;
        reg_sel = {a == (base + 8'h02), a == (base + 8'h01), a == base};
    endfunction : reg_sel

    assign hour_format = cur_hour[`ARM_HOUR_FMT_BIT]; // R4 R5

    for (genvar g = 0; g < 2; g++)
    begin : g_alm
        assign cmp_if[g].sel      = state_reg.alm[g].sel;
        assign cmp_if[g].min_val  = state_reg.alm[g].min;
        // Same bit positions serve both formats; the format bit is shared
        assign cmp_if[g].hour_val = state_reg.alm[g].hour; // R6 R7 R8
        assign cmp_if[g].day_val  = state_reg.alm[g].day;
        assign cmp_if[g].sec_val  = alarm_sec_val[g][6:0];
        assign cmp_if[g].date_val = alarm_date_val[g][5:0];
        assign cmp_if[g].mth_val  = alarm_mth_val[g][4:0];
        assign cmp_if[g].cur_sec  = cur_sec[6:0];
        assign cmp_if[g].cur_min  = cur_min[6:0];
        assign cmp_if[g].cur_hour = cur_hour[5:0]; // R15
        assign cmp_if[g].cur_day  = cur_day_of_week_value[2:0];
        assign cmp_if[g].cur_date = cur_date[5:0];
        assign cmp_if[g].cur_mth  = cur_mth[4:0];
        assign hit[g]             = cmp_if[g].hit;

        arm_alarm_cmp u_cmp (
            .c (cmp_if[g])
        );
    end

    always_comb
    begin
        logic [2:0] sel;
        logic       wk_wr;
        sel        = 3'h0;
        wk_wr      = 1'b0;
        state_next = state_reg;
        for (int i = 0; i < 2; i++)
        begin
            sel   = reg_sel(reg_addr, i[0]);
            wk_wr = reg_wr & sel[2];
            if (reg_wr && sel[0])
            begin
                // Bit 7 dropped
                state_next.alm[i].min =
                    reg_wdata[`ARM_MIN_HI:0]; // R1 R2 R3
            end
            if (reg_wr && sel[1])
            begin
                // Bits 7 and 6 dropped; bit 6 only mirrors the format
                state_next.alm[i].hour =
                    reg_wdata[`ARM_HOUR_HI:0]; // R3 R4
            end
            if (wk_wr)
            begin
                state_next.pol = reg_wdata[`ARM_WK_POL_BIT]; // R9
                state_next.alm[i].sel =
                    reg_wdata[`ARM_WK_SEL_HI:`ARM_WK_SEL_LO]; // R12
                state_next.alm[i].day =
                    reg_wdata[`ARM_WK_DAY_HI:0]; // R16
            end
            // Written flag bit is ignored; a match wins over the clear
            state_next.alm[i].flag = (alarm_enable[i] & hit[i]) // R13 R14
                | (state_reg.alm[i].flag & ~wk_wr); // R10 R11
        end
        if (reg_rd)
        begin
            state_next.rdata = `ARM_RD_UNMAPPED;
            for (int i = 0; i < 2; i++)
            begin
                sel = reg_sel(reg_addr, i[0]);
                if (sel[0])
                    state_next.rdata = {1'b0, state_reg.alm[i].min}; // R3
                if (sel[1])
                    state_next.rdata = {1'b0, hour_format,
                                        state_reg.alm[i].hour}; // R3 R4
                if (sel[2])
                    state_next.rdata = {state_reg.pol,
                                        state_reg.alm[i].sel,
                                        state_reg.alm[i].flag,
                                        state_reg.alm[i].day};
            end
        end
        // Flags of disabled alarms stay visible but do not assert the pin
        for (int i = 0; i < 2; i++)
        begin
            any_vec[i] = state_reg.alm[i].flag & alarm_enable[i];
        end
        state_next.out_level = state_reg.pol ? (|any_vec)
                                             : ~(|any_vec); // R9
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                state_reg.alm[i].min  <= `ARM_RST_MIN;
                state_reg.alm[i].hour <= `ARM_RST_HOUR;
                state_reg.alm[i].sel  <= `ARM_RST_SEL;
                state_reg.alm[i].flag <= 1'b0;
                state_reg.alm[i].day  <= `ARM_RST_DAY;
            end
            state_reg.pol       <= `ARM_RST_POL;
            state_reg.rdata     <= `ARM_RST_RDATA;
            state_reg.out_level <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata             = state_reg.rdata;
    assign alarm_interrupt_flag  = {state_reg.alm[1].flag,
                                    state_reg.alm[0].flag};
    assign alarm_output_polarity = state_reg.pol;
    assign alarm_out_level       = state_reg.out_level;

endmodule : arm_match_regs

// [bench/arm_match_regs_properties.sv]
// Checker for the alarm match registers, bound to the register block.
// Assumes one clock domain and the register port contract of the block.
`timescale 1ns/100ps
module arm_match_regs_properties (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] cur_hour,
    input wire logic [1:0] alarm_enable,
    input wire logic [1:0] alarm_interrupt_flag,
    input wire logic       alarm_output_polarity,
    input wire logic       alarm_out_level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    rd_bit7_zero_a: assert property (reg_rd && (reg_addr == 8'h0B ||
        reg_addr == 8'h12) |=> !reg_rdata[7]) else $error("minute bit 7 set");
    fmt_mirror_a: assert property (reg_rd && (reg_addr == 8'h0C ||
        reg_addr == 8'h13) |=> reg_rdata[7:6] == {1'b0, $past(cur_hour[6])})
        else $error("hour format mirror wrong");
    wr_clears0_a: assert property (reg_wr && reg_addr == 8'h0D &&
        !alarm_enable[0] |=> !alarm_interrupt_flag[0])
        else $error("flag 0 not cleared");
    wr_clears1_a: assert property (reg_wr && reg_addr == 8'h14 &&
        !alarm_enable[1] |=> !alarm_interrupt_flag[1])
        else $error("flag 1 not cleared");
    off_no_set_a: assert property ((~$past(alarm_enable) &
        ~$past(alarm_interrupt_flag) & alarm_interrupt_flag) == 2'b00)
        else $error("disabled alarm set flag");
    pol_write_a: assert property (reg_wr && (reg_addr == 8'h0D ||
        reg_addr == 8'h14) |=> alarm_output_polarity == $past(reg_wdata[7]))
        else $error("polarity not written");
    out_level_a: assert property (1'b1 |=> alarm_out_level ==
        ((|$past(alarm_interrupt_flag & alarm_enable)) ~^
        $past(alarm_output_polarity))) else $error("output level wrong");
    flag_hold_a: assert property (alarm_interrupt_flag[0] &&
        !(reg_wr && reg_addr == 8'h0D) |=> alarm_interrupt_flag[0])
        else $error("flag dropped without write");
endmodule : arm_match_regs_properties
bind arm_match_regs arm_match_regs_properties u_props (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cur_hour(cur_hour), .alarm_enable(alarm_enable),
    .alarm_interrupt_flag(alarm_interrupt_flag),
    .alarm_output_polarity(alarm_output_polarity),
    .alarm_out_level(alarm_out_level));

// [bench/arm_host_model.sv]
// Host side of the register port: single byte writes and reads.
// Assumes strobes are one-cycle pulses launched at the falling edge.
`timescale 1ns/100ps
module arm_host_model (
    input wire logic       clk_sys,
    output logic     [7:0] reg_addr,
    output logic     [7:0] reg_wdata,
    output logic           reg_wr,
    output logic           reg_rd,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        // Data inverted after the strobe so a late sample shows up
        reg_wdata = ~d;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : arm_host_model

// [bench/arm_match_regs_tb.sv]
// Testbench for the alarm match registers with a host model.
// Assumes the bus engine and time counters are replaced by bench drive.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: %h not %h", $time, (a), (e)); end end
module arm_match_regs_tb;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic       reg_wr, reg_rd, pol, lvl;
    logic [7:0] cur_sec = 8'h00, cur_min = 8'h00, cur_hour = 8'h00;
    logic [7:0] cur_day_of_week_value = 8'h00;
    logic [1:0] en = 2'b00, flag;
    int         n_fail = 0, num_checks = 0, cyc = 0;
    always #50 clk_sys = ~clk_sys;
    arm_host_model u_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    arm_match_regs u_dut (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_sec(cur_sec),
        .cur_min(cur_min), .cur_hour(cur_hour), .cur_day_of_week_value(cur_day_of_week_value),
        .cur_date(8'h00), .cur_mth(8'h00), .alarm_sec_val(16'h0000),
        .alarm_date_val(16'h0000), .alarm_mth_val(16'h0000),
        .alarm_enable(en), .alarm_interrupt_flag(flag),
        .alarm_output_polarity(pol), .alarm_out_level(lvl));
    task give_verdict;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    // Whole run is well under a thousand cycles
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    initial
    begin
        logic [7:0] ad [6];
        logic [7:0] rv [6];
        ad = '{8'h0B, 8'h0C, 8'h0D, 8'h12, 8'h13, 8'h14};
        rv = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};
        repeat (8) @(negedge clk_sys);
        rstn = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            u_host.rd(ad[i], d);
            `CHK(d, rv[i])
        end
        u_host.rd(8'h20, d);
        `CHK(d, 8'h00)
        u_host.wr(8'h0B, 8'hFF);
        u_host.rd(8'h0B, d);
        `CHK(d, 8'h7F)
        u_host.wr(8'h0C, 8'hFF);
        u_host.rd(8'h0C, d);
        `CHK(d, 8'h3F)
        cur_hour = 8'h40;
        u_host.rd(8'h0C, d);
        `CHK(d, 8'h7F)
        u_host.wr(8'h0B, 8'h45);
        u_host.rd(8'h0B, d);
        `CHK(d, 8'h45)
        u_host.wr(8'h0D, 8'h91);
        cur_min = 8'h45;
        en = 2'b01;
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b01)
        `CHK(lvl, 1'b1)
        `CHK(pol, 1'b1)
        u_host.rd(8'h0D, d);
        `CHK(d, 8'h99)
        u_host.wr(8'h0D, 8'h91);
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b01)
        // Reserved select, flag bit one; old select still matches at the write
        u_host.wr(8'h0D, 8'h59);
        `CHK(flag, 2'b01)
        u_host.wr(8'h0D, 8'h59);
        `CHK(flag, 2'b00)
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b00)
        `CHK(lvl, 1'b1)
        u_host.wr(8'h14, 8'h08);
        u_host.rd(8'h14, d);
        `CHK(d, 8'h00)
        u_host.wr(8'h13, 8'h31);
        u_host.wr(8'h14, 8'hA1);
        cur_hour = 8'h71;
        en = 2'b11;
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b10)
        `CHK(lvl, 1'b1)
        u_host.rd(8'h13, d);
        `CHK(d, 8'h71)
        cur_hour = 8'h51;
        u_host.wr(8'h14, 8'hA1);
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b00)
        `CHK(lvl, 1'b0)
        cur_hour = 8'h23;
        u_host.wr(8'h13, 8'h23);
        repeat (2) @(negedge clk_sys);
        `CHK(flag, 2'b10)
        u_host.rd(8'h13, d);
        `CHK(d, 8'h23)
        give_verdict();
    end
endmodule : arm_match_regs_tb
